/* src/ccp_pkg.sv */
package ccp_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_FIRST_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_SECOND_FLAGS = 8'h0d;
  localparam logic [7:0] IDX_TB_COUNT = 8'h11;
  localparam logic [7:0] IDX_TB_CTRL = 8'h12;
  localparam logic [7:0] IDX_FIRST_LOW = 8'h15;
  localparam logic [7:0] IDX_FIRST_HIGH = 8'h16;
  localparam logic [7:0] IDX_FIRST_CTRL = 8'h17;
  localparam logic [7:0] IDX_SECOND_LOW = 8'h1b;
  localparam logic [7:0] IDX_SECOND_HIGH = 8'h1c;
  localparam logic [7:0] IDX_SECOND_CTRL = 8'h1d;
  localparam logic [7:0] IDX_FIRST_EN = 8'h8c;
  localparam logic [7:0] IDX_SECOND_EN = 8'h8d;
  localparam logic [7:0] IDX_TB_PERIOD = 8'h92;
  // flag and enable bit positions
  localparam int BIT_FIRST_EVENT = 2;
  localparam int BIT_TB_FLAG = 1;
  localparam int BIT_SECOND_EVENT = 0;
  // unit control fields
  localparam int CTRL_DUTY_LSB = 4;
  localparam logic [7:0] CTRL_WMASK = 8'h3f;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // unit modes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4 = 4'h6;
  localparam logic [3:0] MODE_CAP_16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
  localparam logic [1:0] GRP_CAP = 2'h1;
  localparam logic [1:0] GRP_CMP = 2'h2;
  localparam logic [1:0] GRP_PWM = 2'h3;
  localparam logic [3:0] CAP_MASK_4 = 4'h3;
  localparam logic [3:0] CAP_MASK_16 = 4'hf;
  // timebase control fields and reset values
  localparam int TB_ON_BIT = 2;
  localparam int TB_POST_LSB = 3;
  localparam logic [7:0] TB_CTRL_WMASK = 8'h7f;
  localparam logic [7:0] TB_CTRL_RST = 8'h00;
  localparam logic [7:0] TB_COUNT_RST = 8'h00;
  localparam logic [7:0] TB_PERIOD_RST = 8'hff;
  localparam logic [3:0] PRE_LIMIT_1 = 4'h0;
  localparam logic [3:0] PRE_LIMIT_4 = 4'h3;
  localparam logic [3:0] PRE_LIMIT_16 = 4'hf;
  // one instruction cycle is four input clocks
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  function automatic logic ccp_hit(input logic [9:0] addr, input logic [7:0] idx);
    return (addr[1:0] == 2'h0) && (addr[9:2] == idx);
  endfunction : ccp_hit
endpackage : ccp_pkg

/* src/ccp_tb_if.sv */
`timescale 1ns/100ps
interface ccp_tb_if;
  logic wr_count;
  logic wr_ctrl;
  logic wr_period;
  logic [7:0] wdata;
  logic [7:0] count;
  logic [7:0] ctrl;
  logic [7:0] period;
  logic [1:0] fine;
  logic period_end;
  logic post_match;
  modport owner (output wr_count, wr_ctrl, wr_period, wdata,
    input count, ctrl, period, fine, period_end, post_match);
  modport timebase (input wr_count, wr_ctrl, wr_period, wdata,
    output count, ctrl, period, fine, period_end, post_match);
endinterface : ccp_tb_if

/* src/ccp_timebase.sv */
`timescale 1ns/100ps
module ccp_timebase
  import ccp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register side
  ccp_tb_if.timebase tb
);
  logic [1:0] quarter_r;
  logic [3:0] pre_r;
  logic [3:0] post_r;
  logic [7:0] count_r;
  logic [7:0] ctrl_r;
  logic [7:0] period_r;
  logic end_r;
  logic post_r_hit;
  logic [3:0] pre_limit;
  logic instr_tick;
  logic inc;
  logic wrap;

  always_comb
  begin
    unique case (ctrl_r[1:0])
      2'h0: pre_limit = PRE_LIMIT_1;
      2'h1: pre_limit = PRE_LIMIT_4;
      default: pre_limit = PRE_LIMIT_16;
    endcase
  end

  assign instr_tick = (quarter_r == QUARTER_LAST);
  assign inc = ctrl_r[TB_ON_BIT] && instr_tick && (pre_r == pre_limit);
  assign wrap = inc && (count_r == period_r);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      quarter_r <= 2'h0;
    else
      quarter_r <= quarter_r + 2'h1;
  end

  // prescaler, cleared by writes to count or control
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tb.wr_count || tb.wr_ctrl)
      pre_r <= 4'h0;
    else if (ctrl_r[TB_ON_BIT] && instr_tick)
      pre_r <= (pre_r == pre_limit) ? 4'h0 : pre_r + 4'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_r <= TB_COUNT_RST;
    else if (tb.wr_count)
      count_r <= tb.wdata;
    else if (wrap)
      count_r <= 8'h00;
    else if (inc)
      count_r <= count_r + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_r <= TB_CTRL_RST;
    else if (tb.wr_ctrl)
      ctrl_r <= tb.wdata & TB_CTRL_WMASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      period_r <= TB_PERIOD_RST;
    else if (tb.wr_period)
      period_r <= tb.wdata;
  end

  // period end drives the pwm; the postscaler only feeds the timebase flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      end_r <= 1'b0;
    else
      end_r <= wrap;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || tb.wr_count || tb.wr_ctrl)
    begin
      post_r <= 4'h0;
      post_r_hit <= 1'b0;
    end
    else
    begin
      post_r_hit <= wrap && (post_r == ctrl_r[TB_POST_LSB +: 4]);
      if (wrap)
        post_r <= (post_r == ctrl_r[TB_POST_LSB +: 4]) ? 4'h0 : post_r + 4'h1;
    end
  end

  // fine phase: quarter cycle at 1:1, low prescaler bits at 1:4, top two prescaler bits at 1:16
  always_comb
  begin
    unique case (ctrl_r[1:0])
      2'h0: tb.fine = quarter_r;
      2'h1: tb.fine = pre_r[1:0];
      default: tb.fine = pre_r[3:2];
    endcase
  end

  assign tb.count = count_r;
  assign tb.ctrl = ctrl_r;
  assign tb.period = period_r;
  assign tb.period_end = end_r;
  assign tb.post_match = post_r_hit;
endmodule : ccp_timebase

/* src/ccp_top.sv */
// How it works
// - mode zero turns the unit off and clears prescaler and output latch.
// - modes 4 to 7 capture on falling, rising, fourth or sixteenth rising edge.
// - mode 8 sets pin on match, mode 9 clears it; both raise the flag.
// - mode 10 only raises the flag on match; pin untouched.
// - mode 11 raises flag and trigger; trigger resets counter, second also starts conversion when adc_enable_i is high.
// - modes 11xx are pwm; control bits 5:4 are the duty low bits.
// - capture copies the 16-bit count into the value pair and raises the flag.
// - a new capture overwrites the old value with no overrun indication.
// - capture prescaler clears when off, outside capture modes, and on reset.
// - switching between capture prescales keeps the prescaler count.
// - the edge detector watches the pin level even when driven as output.
// - compare checks value against count continuously; match acts and flags together.
// - writing zero to control forces the output latch low.
// - the trigger that resets the counter does not raise its overflow flag.
// - at period end timebase clears, pin sets unless zero duty, duty is latched.
// - duty takes effect only at period end; high byte read-only in pwm.
// - pin clears when latched duty equals timebase count with fine phase bits.
// - duty beyond the period keeps the pin set for the whole period.
// - pwm period depends only on timebase, prescaler and period limit.
// - timebase counts up to the period limit, then wraps; prescale 1, 4, 16.
// - the period limit resets to all ones.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
module ccp_top
  import ccp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // shared counter
  input wire logic [15:0] t1_count_i,
  output logic t1_reset_o,
  // converter
  input wire logic adc_enable_i,
  output logic adc_start_o,
  // unit pins
  input wire logic [1:0] unit_pin_i,
  output logic [1:0] unit_pin_o
);
  localparam int UNITS = 2;
  localparam logic [7:0] LOW_IDX [UNITS] = '{IDX_FIRST_LOW, IDX_SECOND_LOW};
  localparam logic [7:0] HIGH_IDX [UNITS] = '{IDX_FIRST_HIGH, IDX_SECOND_HIGH};
  localparam logic [7:0] CTRL_IDX [UNITS] = '{IDX_FIRST_CTRL, IDX_SECOND_CTRL};

  ccp_tb_if tb_if ();

  logic wait_r;
  logic [31:0] rdata_r;
  logic commit;
  logic [7:0] wbyte;
  logic [7:0] rd;

  logic [7:0] ctrl_r [UNITS];
  logic [7:0] low_r [UNITS];
  logic [7:0] high_r [UNITS];
  logic [1:0] lat2_r [UNITS];
  logic latch_r [UNITS];
  logic s1_r [UNITS];
  logic s2_r [UNITS];
  logic prev_r [UNITS];
  logic [3:0] capcnt_r [UNITS];
  logic cmpeq_r [UNITS];
  logic flag_r [UNITS];
  logic en_r [UNITS];
  logic tbflag_r;
  logic tben_r;
  logic trig_r;
  logic adc_r;

  logic ev [UNITS];
  logic trig [UNITS];
  logic cap_ev [UNITS];

  ccp_timebase u_timebase (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tb (tb_if.timebase)
  );

  // bus slave: one wait cycle; read data latched at the edge that drops waitrequest, write at the next edge
  assign commit = !wait_r && avs_write_i && avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[7:0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wait_r <= 1'b1;
    else if (wait_r && (avs_read_i || avs_write_i))
      wait_r <= 1'b0;
    else
      wait_r <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_r <= 32'h0000_0000;
    else if (wait_r && avs_read_i)
      rdata_r <= {24'h00_0000, rd};
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;

  assign tb_if.wr_count = commit && ccp_hit(avs_address_i, IDX_TB_COUNT);
  assign tb_if.wr_ctrl = commit && ccp_hit(avs_address_i, IDX_TB_CTRL);
  assign tb_if.wr_period = commit && ccp_hit(avs_address_i, IDX_TB_PERIOD);
  assign tb_if.wdata = wbyte;

  // read mux, unmapped reads return zero
  always_comb
  begin
    rd = 8'h00;
    if (ccp_hit(avs_address_i, IDX_FIRST_FLAGS))
    begin
      rd[BIT_FIRST_EVENT] = flag_r[0];
      rd[BIT_TB_FLAG] = tbflag_r;
    end
    if (ccp_hit(avs_address_i, IDX_SECOND_FLAGS))
      rd[BIT_SECOND_EVENT] = flag_r[1];
    if (ccp_hit(avs_address_i, IDX_FIRST_EN))
    begin
      rd[BIT_FIRST_EVENT] = en_r[0];
      rd[BIT_TB_FLAG] = tben_r;
    end
    if (ccp_hit(avs_address_i, IDX_SECOND_EN))
      rd[BIT_SECOND_EVENT] = en_r[1];
    if (ccp_hit(avs_address_i, IDX_TB_COUNT))
      rd = tb_if.count;
    if (ccp_hit(avs_address_i, IDX_TB_CTRL))
      rd = tb_if.ctrl;
    if (ccp_hit(avs_address_i, IDX_TB_PERIOD))
      rd = tb_if.period;
    for (int u = 0; u < UNITS; u++)
    begin
      if (ccp_hit(avs_address_i, LOW_IDX[u]))
        rd = low_r[u];
      if (ccp_hit(avs_address_i, HIGH_IDX[u]))
        rd = high_r[u];
      if (ccp_hit(avs_address_i, CTRL_IDX[u]))
        rd = ctrl_r[u];
    end
  end

  // timebase flag and enable, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tbflag_r <= 1'b0;
    else if (tb_if.post_match)
      tbflag_r <= 1'b1;
    else if (commit && ccp_hit(avs_address_i, IDX_FIRST_FLAGS))
      tbflag_r <= wbyte[BIT_TB_FLAG];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tben_r <= 1'b0;
    else if (commit && ccp_hit(avs_address_i, IDX_FIRST_EN))
      tben_r <= wbyte[BIT_TB_FLAG];
  end

  // special event trigger; the counter overflow flag is outside and untouched
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig_r <= 1'b0;
      adc_r <= 1'b0;
    end
    else
    begin
      trig_r <= trig[0] || trig[1];
      adc_r <= trig[1] && adc_enable_i;
    end
  end

  assign t1_reset_o = trig_r;
  assign adc_start_o = adc_r;

  for (genvar u = 0; u < UNITS; u++)
  begin : g_unit
    localparam logic [7:0] FLAG_IDX = (u == 0) ? IDX_FIRST_FLAGS : IDX_SECOND_FLAGS;
    localparam logic [7:0] EN_IDX = (u == 0) ? IDX_FIRST_EN : IDX_SECOND_EN;
    localparam int FBIT = (u == 0) ? BIT_FIRST_EVENT : BIT_SECOND_EVENT;
    logic [3:0] mode;
    logic is_cap;
    logic is_cmp;
    logic is_pwm;
    logic rise;
    logic fall;
    logic cmp_eq;
    logic cmp_ev;
    logic [9:0] duty_new;

    assign mode = ctrl_r[u][3:0];
    assign is_cap = (mode[3:2] == GRP_CAP);
    assign is_cmp = (mode[3:2] == GRP_CMP);
    assign is_pwm = (mode[3:2] == GRP_PWM);
    assign rise = s2_r[u] && !prev_r[u];
    assign fall = !s2_r[u] && prev_r[u];
    assign duty_new = {low_r[u], ctrl_r[u][CTRL_DUTY_LSB +: 2]};

    // pin level is sampled regardless of its direction
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        s1_r[u] <= 1'b0;
        s2_r[u] <= 1'b0;
        prev_r[u] <= 1'b0;
      end
      else
      begin
        s1_r[u] <= unit_pin_i[u];
        s2_r[u] <= s1_r[u];
        prev_r[u] <= s2_r[u];
      end
    end

    always_comb
    begin
      unique case (mode)
        MODE_CAP_FALL: cap_ev[u] = fall;
        MODE_CAP_RISE: cap_ev[u] = rise;
        MODE_CAP_4: cap_ev[u] = rise && (capcnt_r[u][1:0] == CAP_MASK_4[1:0]);
        MODE_CAP_16: cap_ev[u] = rise && (capcnt_r[u] == CAP_MASK_16);
        default: cap_ev[u] = 1'b0;
      endcase
    end

    // prescale count survives a switch between capture modes
    always_ff @(posedge clk_i)
    begin
      if (rst_i || !is_cap)
        capcnt_r[u] <= 4'h0;
      else if (rise)
        capcnt_r[u] <= capcnt_r[u] + 4'h1;
    end

    assign cmp_eq = is_cmp && ({high_r[u], low_r[u]} == t1_count_i);
    assign cmp_ev = cmp_eq && !cmpeq_r[u];
    assign ev[u] = cap_ev[u] || cmp_ev;
    assign trig[u] = cmp_ev && (mode == MODE_CMP_TRIG);

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        cmpeq_r[u] <= 1'b0;
      else
        cmpeq_r[u] <= cmp_eq;
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        ctrl_r[u] <= CTRL_RST;
      else if (commit && ccp_hit(avs_address_i, CTRL_IDX[u]))
        ctrl_r[u] <= wbyte & CTRL_WMASK;
    end

    // capture overwrites any unread value
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        low_r[u] <= 8'h00;
      else if (cap_ev[u])
        low_r[u] <= t1_count_i[7:0];
      else if (commit && ccp_hit(avs_address_i, LOW_IDX[u]))
        low_r[u] <= wbyte;
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        high_r[u] <= 8'h00;
      else if (cap_ev[u])
        high_r[u] <= t1_count_i[15:8];
      else if (is_pwm && tb_if.period_end)
        high_r[u] <= low_r[u];
      else if (!is_pwm && commit && ccp_hit(avs_address_i, HIGH_IDX[u]))
        high_r[u] <= wbyte;
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i || mode == MODE_OFF)
        lat2_r[u] <= 2'h0;
      else if (is_pwm && tb_if.period_end)
        lat2_r[u] <= ctrl_r[u][CTRL_DUTY_LSB +: 2];
    end

    // output latch shared by compare and pwm
    always_ff @(posedge clk_i)
    begin
      if (rst_i || mode == MODE_OFF)
        latch_r[u] <= 1'b0;
      else if (cmp_ev && mode == MODE_CMP_SET)
        latch_r[u] <= 1'b1;
      else if (cmp_ev && mode == MODE_CMP_CLR)
        latch_r[u] <= 1'b0;
      else if (is_pwm && tb_if.period_end)
        latch_r[u] <= (duty_new != 10'h000);
      else if (is_pwm && {high_r[u], lat2_r[u]} == {tb_if.count, tb_if.fine})
        latch_r[u] <= 1'b0;
    end

    assign unit_pin_o[u] = latch_r[u];

    // event flag stays until software writes zero; set wins
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        flag_r[u] <= 1'b0;
      else if (ev[u])
        flag_r[u] <= 1'b1;
      else if (commit && ccp_hit(avs_address_i, FLAG_IDX))
        flag_r[u] <= wbyte[FBIT];
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        en_r[u] <= 1'b0;
      else if (commit && ccp_hit(avs_address_i, EN_IDX))
        en_r[u] <= wbyte[FBIT];
    end
  end
endmodule : ccp_top

/* tb/ccp_far_model.sv */
`timescale 1ns/100ps
module ccp_far_model
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench controls
  input wire logic run_i,
  input wire logic [1:0] dir_out_i,
  input wire logic [1:0] ext_lvl_i,
  // design side
  input wire logic t1_reset_i,
  input wire logic [1:0] unit_pin_drv_i,
  output logic [15:0] count_o,
  output logic [1:0] pin_o
);
  // shared counter on the unit clock, frozen while run is low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_o <= 16'h0000;
    else if (t1_reset_i)
      count_o <= 16'h0000;
    else if (run_i)
      count_o <= count_o + 16'h0001;
  end
  // pin wire follows the latch when driven as output
  assign pin_o = (dir_out_i & unit_pin_drv_i) | (~dir_out_i & ext_lvl_i);
endmodule : ccp_far_model

/* tb/ccp_top_asserts.sv */
`timescale 1ns/100ps
module ccp_top_asserts
  import ccp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // counter, converter, pins
  input wire logic [15:0] t1_count_i,
  input wire logic t1_reset_o,
  input wire logic adc_enable_i,
  input wire logic adc_start_o,
  input wire logic [1:0] unit_pin_i,
  input wire logic [1:0] unit_pin_o
);
  logic wr_done;
  logic [3:0] mode0_r;
  logic [3:0] mode1_r;
  logic keep0;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  assign wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign keep0 = (mode0_r == MODE_CMP_SOFT) || (mode0_r == MODE_CMP_TRIG);
  // shadow of the mode fields as software wrote them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode0_r <= MODE_OFF;
    else if (wr_done && avs_address_i == {IDX_FIRST_CTRL, 2'b00})
      mode0_r <= avs_writedata_i[3:0];
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode1_r <= MODE_OFF;
    else if (wr_done && avs_address_i == {IDX_SECOND_CTRL, 2'b00})
      mode1_r <= avs_writedata_i[3:0];
  end
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("no answer one cycle after request");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_read_upper: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> avs_waitrequest_o
    && unit_pin_o == 2'h0 && !t1_reset_o && !adc_start_o) else $error("outputs active in reset");
  a_trig_mode: assert property (t1_reset_o |-> $past(mode0_r) == MODE_CMP_TRIG
    || $past(mode1_r) == MODE_CMP_TRIG) else $error("trigger outside trigger mode");
  a_trig_pulse: assert property (t1_reset_o |=> !t1_reset_o)
    else $error("trigger longer than one cycle");
  a_adc_second: assert property (adc_start_o |-> t1_reset_o && $past(adc_enable_i)
    && $past(mode1_r) == MODE_CMP_TRIG) else $error("conversion start without cause");
  a_off_low0: assert property (mode0_r == MODE_OFF && $past(mode0_r) == MODE_OFF
    |-> !unit_pin_o[0]) else $error("first latch high while off");
  a_off_low1: assert property (mode1_r == MODE_OFF && $past(mode1_r) == MODE_OFF
    |-> !unit_pin_o[1]) else $error("second latch high while off");
  a_keep_pin: assert property (keep0 && $past(keep0) && $past(keep0, 2)
    |-> $stable(unit_pin_o[0])) else $error("pin moved in flag or trigger mode");
endmodule : ccp_top_asserts

bind ccp_top ccp_top_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .t1_count_i(t1_count_i), .t1_reset_o(t1_reset_o), .adc_enable_i(adc_enable_i),
  .adc_start_o(adc_start_o), .unit_pin_i(unit_pin_i), .unit_pin_o(unit_pin_o));

/* tb/ccp_top_bench.sv */
`timescale 1ns/100ps
module ccp_top_bench;
  import ccp_pkg::*;
  typedef struct packed {logic [7:0] idx; logic wr; logic [7:0] wd; logic [7:0] exp;} ccp_row_s;
  typedef struct packed {logic u; logic [3:0] mode; logic pin; logic trig; logic adc;} ccp_cmp_s;
  typedef struct packed {logic [7:0] low; logic [1:0] lsb; logic [7:0] tbc; logic [7:0] hi;} ccp_pwm_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] addr = 10'h000;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wait_req;
  logic [15:0] t1_count;
  logic t1_reset;
  logic adc_en = 1'b0;
  logic adc_start;
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic run = 1'b1;
  logic [1:0] dir_out = 2'h0;
  logic [1:0] ext = 2'h0;
  int trig_cnt = 0;
  int adc_cnt = 0;
  logic [7:0] rd;
  logic [7:0] hi;
  logic [15:0] cnt;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  int m;
  logic [3:0] cap_mode [4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_4, MODE_CAP_16};
  int cap_n [4] = '{1, 1, 4, 16};
  ccp_row_s regs [11] = '{'{IDX_FIRST_CTRL, 1'b0, 8'h00, CTRL_RST},
    '{IDX_SECOND_CTRL, 1'b0, 8'h00, CTRL_RST}, '{IDX_SECOND_FLAGS, 1'b0, 8'h00, 8'h00},
    '{IDX_SECOND_EN, 1'b0, 8'h00, 8'h00}, '{IDX_TB_PERIOD, 1'b0, 8'h00, TB_PERIOD_RST},
    '{IDX_TB_COUNT, 1'b0, 8'h00, TB_COUNT_RST}, '{IDX_FIRST_CTRL, 1'b1, 8'hff, 8'h3f},
    '{IDX_FIRST_CTRL, 1'b1, 8'h00, 8'h00}, '{IDX_SECOND_EN, 1'b1, 8'h01, 8'h01},
    '{IDX_SECOND_LOW, 1'b1, 8'ha5, 8'ha5}, '{8'h40, 1'b1, 8'h11, 8'h00}};
  ccp_cmp_s cmps [7] = '{'{1'b0, MODE_CMP_SET, 1'b1, 1'b0, 1'b0},
    '{1'b0, MODE_CMP_SOFT, 1'b1, 1'b0, 1'b0}, '{1'b0, MODE_CMP_CLR, 1'b0, 1'b0, 1'b0},
    '{1'b0, MODE_CMP_TRIG, 1'b0, 1'b1, 1'b0}, '{1'b1, MODE_CMP_TRIG, 1'b0, 1'b1, 1'b1},
    '{1'b1, MODE_CMP_TRIG, 1'b0, 1'b1, 1'b0}, '{1'b1, MODE_CMP_SET, 1'b1, 1'b0, 1'b0}};
  ccp_pwm_s pwms [6] = '{'{8'h01, 2'h2, 8'h04, 8'h06}, '{8'h00, 2'h0, 8'h04, 8'h00},
    '{8'hff, 2'h3, 8'h04, 8'h10}, '{8'h01, 2'h2, 8'h7c, 8'h06},
    '{8'h01, 2'h2, 8'h05, 8'h18}, '{8'h01, 2'h2, 8'h06, 8'h60}};

  ccp_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd_req),
    .avs_write_i(wr_req), .avs_writedata_i(wdata), .avs_byteenable_i(4'h1),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .t1_count_i(t1_count),
    .t1_reset_o(t1_reset), .adc_enable_i(adc_en), .adc_start_o(adc_start),
    .unit_pin_i(pin_in), .unit_pin_o(pin_out));
  ccp_far_model far_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .dir_out_i(dir_out),
    .ext_lvl_i(ext), .t1_reset_i(t1_reset), .unit_pin_drv_i(pin_out), .count_o(t1_count),
    .pin_o(pin_in));

  initial forever #20 clk_i = ~clk_i;

  task wrap_up;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  task bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk_i);
    addr <= {idx, 2'b00};
    rd_req <= !w;
    wr_req <= w;
    wdata <= {24'h00_0000, wd};
    do
      @(posedge clk_i);
    while (wait_req !== 1'b0);
    rd = rdata[7:0];
    rd_req <= 1'b0;
    wr_req <= 1'b0;
  endtask : bus

  task rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk8(rd, exp);
  endtask : rdc

  task flag_is(input logic u, input logic e);
    bus(1'b0, u ? IDX_SECOND_FLAGS : IDX_FIRST_FLAGS, 8'h00);
    chk1(rd[u ? BIT_SECOND_EVENT : BIT_FIRST_EVENT], e);
  endtask : flag_is

  task pulse;
    @(posedge clk_i);
    ext <= 2'h1;
    repeat (6) @(posedge clk_i);
    ext <= 2'h0;
    repeat (6) @(posedge clk_i);
  endtask : pulse

  task freeze;
    run <= 1'b0;
    repeat (2) @(posedge clk_i);
    cnt = t1_count;
  endtask : freeze

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (t1_reset === 1'b1)
      trig_cnt <= trig_cnt + 1;
    if (adc_start === 1'b1)
      adc_cnt <= adc_cnt + 1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      wrap_up();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 11; i++)
    begin
      if (regs[i].wr)
        bus(1'b1, regs[i].idx, regs[i].wd);
      rdc(regs[i].idx, regs[i].exp);
    end
    for (int i = 0; i < 4; i++)
    begin
      run <= 1'b1;
      bus(1'b1, IDX_FIRST_CTRL, {4'h0, cap_mode[i]});
      bus(1'b1, IDX_FIRST_FLAGS, 8'h00);
      freeze();
      repeat (cap_n[i] - 1) pulse();
      flag_is(1'b0, 1'b0);
      pulse();
      flag_is(1'b0, 1'b1);
      rdc(IDX_FIRST_LOW, cnt[7:0]);
      rdc(IDX_FIRST_HIGH, cnt[15:8]);
      bus(1'b1, IDX_FIRST_CTRL, 8'h00);
    end
    run <= 1'b1;
    bus(1'b1, IDX_FIRST_CTRL, {4'h0, MODE_CAP_RISE});
    pulse();
    freeze();
    pulse();
    rdc(IDX_FIRST_LOW, cnt[7:0]);
    rdc(IDX_FIRST_HIGH, cnt[15:8]);
    bus(1'b1, IDX_FIRST_CTRL, {4'h0, MODE_CAP_4});
    // count left at three, so a missed clear fires early
    pulse();
    bus(1'b1, IDX_FIRST_CTRL, 8'h00);
    bus(1'b1, IDX_FIRST_CTRL, {4'h0, MODE_CAP_4});
    bus(1'b1, IDX_FIRST_FLAGS, 8'h00);
    repeat (3) pulse();
    flag_is(1'b0, 1'b0);
    pulse();
    flag_is(1'b0, 1'b1);
    bus(1'b1, IDX_FIRST_CTRL, {4'h0, MODE_CAP_16});
    bus(1'b1, IDX_FIRST_FLAGS, 8'h00);
    repeat (11) pulse();
    flag_is(1'b0, 1'b0);
    pulse();
    flag_is(1'b0, 1'b1);
    bus(1'b1, IDX_FIRST_CTRL, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      adc_en <= cmps[i].adc || !cmps[i].u;
      freeze();
      cnt = cnt + 16'h0028;
      bus(1'b1, cmps[i].u ? IDX_SECOND_LOW : IDX_FIRST_LOW, cnt[7:0]);
      bus(1'b1, cmps[i].u ? IDX_SECOND_HIGH : IDX_FIRST_HIGH, cnt[15:8]);
      bus(1'b1, cmps[i].u ? IDX_SECOND_CTRL : IDX_FIRST_CTRL, {4'h0, cmps[i].mode});
      bus(1'b1, cmps[i].u ? IDX_SECOND_FLAGS : IDX_FIRST_FLAGS, 8'h00);
      n = trig_cnt;
      m = adc_cnt;
      run <= 1'b1;
      while (t1_count !== cnt)
        @(posedge clk_i);
      repeat (6) @(posedge clk_i);
      chk1(pin_out[cmps[i].u], cmps[i].pin);
      flag_is(cmps[i].u, 1'b1);
      chk1(trig_cnt != n, cmps[i].trig);
      chk1(adc_cnt != m, cmps[i].adc);
      if (cmps[i].mode == MODE_CMP_TRIG)
        bus(1'b1, cmps[i].u ? IDX_SECOND_CTRL : IDX_FIRST_CTRL, 8'h00);
    end
    // latch still high; turning the pin to output makes the capture edge
    bus(1'b1, IDX_SECOND_CTRL, {4'h0, MODE_CAP_RISE});
    bus(1'b1, IDX_SECOND_FLAGS, 8'h00);
    flag_is(1'b1, 1'b0);
    dir_out <= 2'h2;
    repeat (6) @(posedge clk_i);
    flag_is(1'b1, 1'b1);
    dir_out <= 2'h0;
    bus(1'b1, IDX_SECOND_CTRL, 8'h00);
    repeat (3) @(posedge clk_i);
    chk1(pin_out[1], 1'b0);
    bus(1'b1, IDX_TB_PERIOD, 8'h03);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, IDX_FIRST_LOW, pwms[i].low);
      bus(1'b1, IDX_TB_CTRL, pwms[i].tbc);
      bus(1'b1, IDX_FIRST_CTRL, {2'b00, pwms[i].lsb, 4'hc});
      repeat (300) @(posedge clk_i);
      n = pwms[i].tbc[1] ? 256 : (pwms[i].tbc[0] ? 64 : 16);
      hi = 8'h00;
      repeat (n)
      begin
        @(posedge clk_i);
        hi = hi + {7'h00, pin_out[0]};
      end
      chk8(hi, pwms[i].hi);
      rdc(IDX_FIRST_HIGH, pwms[i].low);
    end
    bus(1'b1, IDX_FIRST_HIGH, 8'h5a);
    rdc(IDX_FIRST_HIGH, 8'h01);
    wrap_up();
  end
endmodule : ccp_top_bench
